/* File: reset_seq_pkg.sv */
// constants for the reset source and standby resume block
package reset_seq_pkg;
    localparam logic [11:0] cause_flags_addr = 12'hfc6;
    localparam logic [11:0] axi_cause_offset = 12'h000;
    localparam logic [11:0] axi_ctrl_offset = 12'h004;
    localparam logic [11:0] axi_status_offset = 12'h008;
    localparam logic [11:0] axi_pc_offset = 12'h00c;
    localparam logic [11:0] axi_periph_offset = 12'h010;
    localparam int wdf_bit = 2;
    localparam int krf_bit = 3;
    localparam int rbe_bit = 6;
    localparam int mbe_bit = 7;
    localparam int stab_exp_17 = 17;
    localparam int stab_exp_15 = 15;
    localparam int stab_exp_13 = 13;
    localparam logic [7:0] timer_modulo_reset = 8'hff;
    localparam logic [7:0] converter_mode_reset = 8'h04;
    localparam logic [7:0] sa_reset = 8'h7f;
    localparam logic [3:0] stack_bank_reset = 4'h8;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;
    localparam int resume_instr_count = 2;
    typedef enum logic [2:0] {
        st_reset,
        st_stab,
        st_vec_hi,
        st_vec_lo,
        st_run,
        st_standby,
        st_resume
    } seq_state_t;
endpackage : reset_seq_pkg

/* File: key_edge_oneshot.sv */
// synchronised falling edge detector with one-shot output
module key_edge_oneshot #(
    parameter int width = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // key pins and qualifiers
    input wire logic [width-1:0] keys,
    input wire logic arm,
    // result
    output logic pulse
);
    typedef struct packed {
        logic [width-1:0] sync1;
        logic [width-1:0] sync2;
        logic [width-1:0] prev;
        logic pulse;
    } edge_st_t;

    edge_st_t st_reg;
    edge_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = keys;
        st_next.sync2 = st_reg.sync1;
        st_next.prev = st_reg.sync2;
        st_next.pulse = arm && |(st_reg.prev & ~st_reg.sync2);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{default: '1, pulse: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pulse = st_reg.pulse;
endmodule : key_edge_oneshot

/* File: reset_source_and_standby_resume.sv */
// reset merging, stabilisation wait, vector load, cause flags and standby resume
// Functional notes
// - standby ended by external reset fully resets; code still raises standby_reset for it
// - wake with enable 0 continues, request kept
// - wake with enable 1 runs two then vectors
// - testable input wake never vectors
// - three sources merge into internal reset
// - key falling edge in stop gives pulse
// - key reset only with enable pin high
// - stabilisation wait of 2^17/2^15/2^13 periods
// - pc from word 0 nibble and word 1
// - bank enables from word 0 bits 6,7
// - standby reset keeps state, operation reset flags undefined
// - timers cleared, modulo ff, converter 04/7f
// - interrupt state cleared, stack bank 1000b
// - port buffers off, latches and selects zero
// - write address undefined when write interrupted
// - cause flags bits 2 and 3 at fc6
// - external reset clears both cause flags
// - watchdog reset sets watchdog flag only
// - key reset sets key flag only
// - flags stay until external reset or clear
//
// Our own choice: register access over AXI4-Lite.
module reset_source_and_standby_resume #(
    parameter int stab_exp = reset_seq_pkg::stab_exp_17,
    parameter int key_count = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins
    input wire logic reset_pin_n,
    input wire logic keyreturn_reset_enable_pin,
    input wire logic [key_count-1:0] key_return_inputs,
    // core side events
    input wire logic watchdog_overflow,
    input wire logic stop_mode,
    input wire logic halt_mode,
    input wire logic wake_request,
    input wire logic wake_from_testable_edge_input,
    input wire logic global_interrupt_enable,
    input wire logic instr_retired,
    input wire logic nv_write_busy,
    // program memory vector words
    input wire logic [7:0] vector_word0,
    input wire logic [7:0] vector_word1,
    // core side results
    output logic internal_reset,
    output logic standby_reset,
    output logic vector_fetch,
    output logic [11:0] start_pc,
    output logic register_bank_enable,
    output logic memory_bank_enable,
    output logic resume_continue,
    output logic take_vector,
    output logic keep_request_flag,
    output logic nv_addr_undefined,
    // peripheral reset values
    output logic [7:0] timer_modulo,
    output logic [7:0] timer2_high_period_modulo,
    output logic [7:0] converter_mode_register,
    output logic [7:0] successive_approx_register,
    output logic [3:0] stack_bank_select,
    output logic port_output_enable,
    output logic [3:0] port_direction_register,
    output logic [3:0] port_pullup_select,
    output logic watchdog_enable_flag,
    output logic processor_clock_control
);
    localparam int cnt_w = stab_exp + 1;
    localparam logic [cnt_w-1:0] stab_count = cnt_w'(1) << stab_exp;

    typedef struct packed {
        reset_seq_pkg::seq_state_t state;
        logic [cnt_w-1:0] count;
        logic [1:0] rst_sync;
        logic [1:0] en_sync;
        logic [1:0] wdt_pending;
        logic watchdog_cause_flag;
        logic keyreturn_cause_flag;
        logic in_standby;
        logic vec_pending;
        logic [1:0] instr_left;
        logic [11:0] start_pc;
        logic register_bank_enable;
        logic memory_bank_enable;
        logic resume_continue;
        logic take_vector;
        logic keep_request;
        logic nv_undef;
        logic standby_reset;
        logic reset_source_was_standby;
        logic port_oe_sw;
        logic [3:0] port_dir;
        logic [3:0] port_pull;
        logic aw_done;
        logic w_done;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } seq_st_t;

    seq_st_t st_reg;
    seq_st_t st_next;
    logic key_pulse;
    logic ext_reset;
    logic any_reset;
    logic do_write;
    logic clr_wdf;
    logic clr_krf;

    // key reset armed only in stop with enable
    key_edge_oneshot #(
        .width(key_count)
    ) u_key (
        .aclk(aclk),
        .aresetn(aresetn),
        .keys(key_return_inputs),
        .arm(stop_mode && st_reg.en_sync[1]),
        .pulse(key_pulse)
    );

    always_comb begin
        st_next = st_reg;
        ext_reset = st_reg.rst_sync[1] == 1'b0;
        any_reset = ext_reset || watchdog_overflow || key_pulse;
        do_write = 1'b0;
        clr_wdf = 1'b0;
        clr_krf = 1'b0;
        st_next.rst_sync = {st_reg.rst_sync[0], reset_pin_n};
        st_next.en_sync = {st_reg.en_sync[0], keyreturn_reset_enable_pin};
        st_next.in_standby = stop_mode || halt_mode;
        st_next.take_vector = 1'b0;

        // axi write: address and data in either order
        if (s_axi_awvalid && !st_reg.aw_done) begin
            st_next.aw_done = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_done) begin
            st_next.w_done = 1'b1;
            st_next.wdata = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        if (st_reg.aw_done && st_reg.w_done && !st_reg.bvalid) begin
            do_write = 1'b1;
            st_next.aw_done = 1'b0;
            st_next.w_done = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = reset_seq_pkg::axi_okay;
            case (st_reg.awaddr & 12'hffc)
                reset_seq_pkg::axi_cause_offset: begin
                    // write one clears each flag alone
                    clr_wdf = st_reg.wdata[reset_seq_pkg::wdf_bit];
                    clr_krf = st_reg.wdata[reset_seq_pkg::krf_bit];
                end
                reset_seq_pkg::axi_ctrl_offset: begin
                    st_next.port_oe_sw = st_reg.wdata[0];
                    st_next.port_dir = st_reg.wdata[7:4];
                    st_next.port_pull = st_reg.wdata[11:8];
                end
                default: begin
                    st_next.bresp = reset_seq_pkg::axi_slverr;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // axi read
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = reset_seq_pkg::axi_okay;
            st_next.rdata = 32'h0;
            case (s_axi_araddr & 12'hffc)
                reset_seq_pkg::axi_cause_offset: begin
                    // flags at bits 2 and 3
                    st_next.rdata[reset_seq_pkg::wdf_bit] = st_reg.watchdog_cause_flag;
                    st_next.rdata[reset_seq_pkg::krf_bit] = st_reg.keyreturn_cause_flag;
                end
                reset_seq_pkg::axi_ctrl_offset: begin
                    st_next.rdata[0] = st_reg.port_oe_sw;
                    st_next.rdata[7:4] = st_reg.port_dir;
                    st_next.rdata[11:8] = st_reg.port_pull;
                end
                reset_seq_pkg::axi_status_offset: begin
                    st_next.rdata[2:0] = 3'(st_reg.state);
                    st_next.rdata[4] = st_reg.standby_reset;
                    st_next.rdata[5] = st_reg.nv_undef;
                end
                reset_seq_pkg::axi_pc_offset: begin
                    st_next.rdata[11:0] = st_reg.start_pc;
                    st_next.rdata[12] = st_reg.register_bank_enable;
                    st_next.rdata[13] = st_reg.memory_bank_enable;
                end
                default: begin
                    st_next.rresp = reset_seq_pkg::axi_slverr;
                end
            endcase
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // cause flags; a set beats a write-one clear in the same cycle, external reset beats a set
        if (clr_wdf) begin
            st_next.watchdog_cause_flag = 1'b0;
        end
        if (clr_krf) begin
            st_next.keyreturn_cause_flag = 1'b0;
        end
        if (ext_reset) begin
            st_next.watchdog_cause_flag = 1'b0;
            st_next.keyreturn_cause_flag = 1'b0;
        end else begin
            if (watchdog_overflow) begin
                st_next.watchdog_cause_flag = 1'b1;
            end
            if (key_pulse) begin
                // key reset sets its flag only
                st_next.keyreturn_cause_flag = 1'b1;
            end
        end

        if (any_reset) begin
            st_next.state = reset_seq_pkg::st_reset;
            st_next.reset_source_was_standby = st_reg.in_standby
                || (st_reg.state == reset_seq_pkg::st_reset
                && st_reg.reset_source_was_standby);
            if (nv_write_busy) begin
                st_next.nv_undef = 1'b1;
            end
            // port and control state to reset values
            st_next.port_oe_sw = 1'b0;
            st_next.port_dir = 4'h0;
            st_next.port_pull = 4'h0;
            st_next.resume_continue = 1'b0;
            st_next.vec_pending = 1'b0;
        end else begin
            case (st_reg.state)
                reset_seq_pkg::st_reset: begin
                    st_next.count = '0;
                    st_next.standby_reset = st_reg.reset_source_was_standby;
                    st_next.state = reset_seq_pkg::st_stab;
                end
                reset_seq_pkg::st_stab: begin
                    // hold reset for the full count
                    if (st_reg.count == stab_count - cnt_w'(1)) begin
                        st_next.state = reset_seq_pkg::st_vec_hi;
                    end else begin
                        st_next.count = st_reg.count + cnt_w'(1);
                    end
                end
                reset_seq_pkg::st_vec_hi: begin
                    // upper pc nibble from word 0
                    st_next.start_pc[11:8] = vector_word0[3:0];
                    // bank enables from bits 6 and 7
                    st_next.register_bank_enable = vector_word0[reset_seq_pkg::rbe_bit];
                    st_next.memory_bank_enable = vector_word0[reset_seq_pkg::mbe_bit];
                    st_next.state = reset_seq_pkg::st_vec_lo;
                end
                reset_seq_pkg::st_vec_lo: begin
                    st_next.start_pc[7:0] = vector_word1;
                    st_next.nv_undef = 1'b0;
                    st_next.state = reset_seq_pkg::st_run;
                end
                reset_seq_pkg::st_run: begin
                    st_next.resume_continue = 1'b0;
                    if (stop_mode || halt_mode) begin
                        st_next.state = reset_seq_pkg::st_standby;
                    end
                end
                reset_seq_pkg::st_standby: begin
                    if (wake_request) begin
                        st_next.resume_continue = 1'b1;
                        // enable 0 continues and keeps request
                        st_next.keep_request = wake_from_testable_edge_input
                            || !global_interrupt_enable;
                        // enable 1 vectors after two instructions
                        st_next.vec_pending = global_interrupt_enable
                            && !wake_from_testable_edge_input;
                        st_next.instr_left = 2'(reset_seq_pkg::resume_instr_count);
                        st_next.state = reset_seq_pkg::st_resume;
                    end
                end
                reset_seq_pkg::st_resume: begin
                    st_next.resume_continue = 1'b0;
                    if (!st_reg.vec_pending) begin
                        st_next.state = reset_seq_pkg::st_run;
                    end else if (instr_retired && st_reg.instr_left == 2'd1) begin
                        st_next.take_vector = 1'b1;
                        st_next.vec_pending = 1'b0;
                        st_next.state = reset_seq_pkg::st_run;
                    end else if (instr_retired) begin
                        st_next.instr_left = st_reg.instr_left - 2'd1;
                    end
                end
                default: begin
                    st_next.state = reset_seq_pkg::st_reset;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{state: reset_seq_pkg::st_reset, rst_sync: 2'b00,
                start_pc: 12'h000, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // internal reset until vector fetch starts
    assign internal_reset = st_reg.state == reset_seq_pkg::st_reset
        || st_reg.state == reset_seq_pkg::st_stab;
    assign vector_fetch = st_reg.state == reset_seq_pkg::st_vec_hi;
    assign standby_reset = st_reg.standby_reset;
    assign start_pc = st_reg.start_pc;
    assign register_bank_enable = st_reg.register_bank_enable;
    assign memory_bank_enable = st_reg.memory_bank_enable;
    assign resume_continue = st_reg.resume_continue;
    assign take_vector = st_reg.take_vector;
    assign keep_request_flag = st_reg.keep_request;
    assign nv_addr_undefined = st_reg.nv_undef;
    assign timer_modulo = reset_seq_pkg::timer_modulo_reset;
    assign timer2_high_period_modulo = reset_seq_pkg::timer_modulo_reset;
    assign converter_mode_register = reset_seq_pkg::converter_mode_reset;
    assign successive_approx_register = reset_seq_pkg::sa_reset;
    assign stack_bank_select = reset_seq_pkg::stack_bank_reset;
    // outputs off while reset is held
    assign port_output_enable = st_reg.port_oe_sw && !internal_reset;
    assign port_direction_register = st_reg.port_dir;
    assign port_pullup_select = st_reg.port_pull;
    assign watchdog_enable_flag = 1'b0;
    assign processor_clock_control = 1'b0;

    assign s_axi_awready = !st_reg.aw_done;
    assign s_axi_wready = !st_reg.w_done;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
endmodule : reset_source_and_standby_resume

/* File: reset_source_and_standby_resume_props.sv */
// assertions on the reset sequencer ports
module reset_source_and_standby_resume_props #(
    parameter int stab_exp = 17
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // sources and qualifiers
    input wire logic reset_pin_n,
    input wire logic watchdog_overflow,
    input wire logic stop_mode,
    input wire logic halt_mode,
    input wire logic wake_request,
    input wire logic wake_from_testable_edge_input,
    input wire logic global_interrupt_enable,
    input wire logic instr_retired,
    input wire logic [7:0] vector_word0,
    input wire logic [7:0] vector_word1,
    // results
    input wire logic internal_reset,
    input wire logic vector_fetch,
    input wire logic [11:0] start_pc,
    input wire logic register_bank_enable,
    input wire logic memory_bank_enable,
    input wire logic resume_continue,
    input wire logic take_vector,
    input wire logic keep_request_flag,
    input wire logic [7:0] timer_modulo,
    input wire logic [7:0] converter_mode_register,
    input wire logic [7:0] successive_approx_register,
    input wire logic [3:0] stack_bank_select,
    input wire logic port_output_enable
);
    logic [19:0] held_reg;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn || !internal_reset) begin
            held_reg <= 20'h0;
        end else begin
            held_reg <= held_reg + 20'h1;
        end
    end
    a_stab_long: assert property (
        $fell(internal_reset) |-> held_reg >= (20'h1 << stab_exp))
        else $error("reset too short");
    a_fetch_once: assert property ($fell(internal_reset) |-> vector_fetch ##1 !vector_fetch)
        else $error("vector fetch not one cycle");
    a_wdog_merge: assert property (watchdog_overflow |=> internal_reset)
        else $error("watchdog gave no reset");
    a_pin_merge: assert property (!reset_pin_n |-> ##[1:4] internal_reset)
        else $error("pin gave no reset");
    a_pc_load: assert property (
        vector_fetch |-> ##[1:3] (start_pc == {vector_word0[3:0], vector_word1}))
        else $error("start pc wrong");
    a_bank_load: assert property (
        vector_fetch |-> ##[1:3] ({memory_bank_enable, register_bank_enable} == vector_word0[7:6]))
        else $error("bank enables wrong");
    a_periph_vals: assert property ($rose(internal_reset) |=>
        {timer_modulo, converter_mode_register, successive_approx_register, stack_bank_select}
        == 28'hff047f8)
        else $error("reset value wrong");
    a_port_off: assert property (internal_reset |-> !port_output_enable)
        else $error("port buffer on in reset");
    a_resume_next: assert property (
        (halt_mode || stop_mode) && wake_request && !internal_reset |-> ##[1:2] resume_continue)
        else $error("no resume");
    a_vector_cause: assert property (
        take_vector |-> $past(instr_retired) && global_interrupt_enable
        && !wake_from_testable_edge_input)
        else $error("bad vector");
    a_keep_req: assert property (
        resume_continue && !global_interrupt_enable |-> ##[0:1] keep_request_flag)
        else $error("request not kept");
endmodule : reset_source_and_standby_resume_props

bind reset_source_and_standby_resume reset_source_and_standby_resume_props #(.stab_exp(stab_exp))
    i_props (.*);

/* File: key_pin_model.sv */
// far side pins: reset button and key inputs, both with pull-ups
module key_pin_model (
    // clock
    input wire logic aclk,
    // bench commands
    input wire logic reset_req,
    input wire logic [3:0] key_req,
    input wire logic arm,
    // pins
    output logic reset_pin_n,
    output logic keyreturn_reset_enable_pin,
    output logic [3:0] key_return_inputs
);
    timeunit 1ns;
    timeprecision 1ps;
    int rst_cnt = 0, key_cnt = 0;
    logic [3:0] key_sel = 4'h0;
    assign keyreturn_reset_enable_pin = arm;
    // released pins float to the pull-up level
    assign reset_pin_n = (rst_cnt == 0);
    assign key_return_inputs = (key_cnt == 0) ? 4'hf : ~key_sel;
    always @(posedge aclk) begin
        if (reset_req) begin
            rst_cnt <= 8;
        end else if (rst_cnt != 0) begin
            rst_cnt <= rst_cnt - 1;
        end
        if (key_req != 4'h0) begin
            key_sel <= key_req;
            key_cnt <= 6;
        end else if (key_cnt != 0) begin
            key_cnt <= key_cnt - 1;
        end
    end
endmodule : key_pin_model

/* File: reset_source_and_standby_resume_tb_top.sv */
// bench for the reset sequencer
module reset_source_and_standby_resume_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int stab_exp = 4;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, start_pc;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0, key_return_inputs, key_req = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, reset_req = 1'b0, arm = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic reset_pin_n, keyreturn_reset_enable_pin, watchdog_overflow = 1'b0;
    logic stop_mode = 1'b0, halt_mode = 1'b0, wake_request = 1'b0, instr_retired = 1'b0;
    logic wake_from_testable_edge_input = 1'b0, global_interrupt_enable = 1'b0;
    logic nv_write_busy = 1'b0, rc, tv, kq;
    logic [7:0] vector_word0 = 8'h45, vector_word1 = 8'ha7;
    logic internal_reset, standby_reset, vector_fetch, register_bank_enable;
    logic memory_bank_enable, resume_continue, take_vector, keep_request_flag;
    logic nv_addr_undefined, port_output_enable, watchdog_enable_flag, processor_clock_control;
    logic [7:0] timer_modulo, timer2_high_period_modulo;
    logic [7:0] converter_mode_register, successive_approx_register;
    logic [3:0] stack_bank_select, port_direction_register, port_pullup_select;
    int fails = 0, num_checks = 0;
    reset_source_and_standby_resume #(.stab_exp(stab_exp)) i_reset_source_and_standby_resume (.*);
    key_pin_model i_key_pin_model (.*);
    always #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic aw_ok = 1'b0, w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        {r, d} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 500 && s !== 1'b1; n++) @(posedge aclk);
    endtask : wait_hi
    // waits out reset, checks the loaded vector
    task automatic boot;
        wait_hi(vector_fetch);
        repeat (4) @(posedge aclk);
        chk(32'(start_pc), 32'({vector_word0[3:0], vector_word1}));
        chk(32'({memory_bank_enable, register_bank_enable}), 32'(vector_word0[7:6]));
        chk(32'({port_pullup_select, port_direction_register, port_output_enable}), 32'h0);
    endtask : boot
    task automatic flags(input logic [31:0] exp);
        rd(reset_seq_pkg::axi_cause_offset);
        chk(d & 32'hc, exp);
    endtask : flags

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        boot();
        chk(32'({timer2_high_period_modulo, converter_mode_register, successive_approx_register}),
            32'hff047f);
        chk(32'({stack_bank_select, watchdog_enable_flag, processor_clock_control}), 32'h20);
        flags(32'h0);
        wr(reset_seq_pkg::axi_ctrl_offset, 32'ha51);
        chk(32'({port_pullup_select, port_direction_register, port_output_enable}), 32'h14b);
        rd(12'h100);
        chk({r, d[29:0]}, {reset_seq_pkg::axi_slverr, 30'h0});
        // watchdog reset mid nv write, new vector words
        {vector_word0, vector_word1} <= 16'h831e;
        {watchdog_overflow, nv_write_busy} <= 2'b11;
        @(posedge aclk);
        {watchdog_overflow, nv_write_busy} <= 2'b00;
        @(posedge aclk);
        chk(32'(nv_addr_undefined), 32'h1);
        boot();
        flags(32'h1 << reset_seq_pkg::wdf_bit);
        chk(32'(standby_reset), 32'h0);
        // key edge in stop, enable pin low then high
        stop_mode <= 1'b1;
        key_req <= 4'h2;
        @(posedge aclk);
        key_req <= 4'h0;
        repeat (12) @(posedge aclk);
        chk(32'(internal_reset), 32'h0);
        arm <= 1'b1;
        key_req <= 4'h8;
        @(posedge aclk);
        key_req <= 4'h0;
        wait_hi(internal_reset);
        chk(32'(internal_reset), 32'h1);
        {stop_mode, arm} <= 2'b00;
        boot();
        flags(32'hc);
        chk(32'(standby_reset), 32'h1);
        wr(reset_seq_pkg::axi_cause_offset, 32'h1 << reset_seq_pkg::wdf_bit);
        flags(32'h1 << reset_seq_pkg::krf_bit);
        // external reset while halted
        halt_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        reset_req <= 1'b1;
        @(posedge aclk);
        reset_req <= 1'b0;
        wait_hi(internal_reset);
        halt_mode <= 1'b0;
        boot();
        flags(32'h0);
        // wake: enable 0, enable 1, testable input
        for (int k = 0; k < 3; k++) begin
            global_interrupt_enable <= (k != 0);
            wake_from_testable_edge_input <= (k == 2);
            halt_mode <= 1'b1;
            repeat (3) @(posedge aclk);
            wake_request <= 1'b1;
            @(posedge aclk);
            {wake_request, halt_mode} <= 2'b00;
            {rc, tv, kq} = 3'b000;
            for (int i = 0; i < 8; i++) begin
                @(posedge aclk);
                instr_retired <= (i == 1 || i == 3);
                {rc, tv, kq} = {rc, tv, kq} | {resume_continue, take_vector, keep_request_flag};
            end
            chk(32'({rc, tv}), 32'({1'b1, k == 1}));
            if (k == 0) chk(32'(kq), 32'h1);
        end
        results();
    end

    // a hang ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        results();
    end
endmodule : reset_source_and_standby_resume_tb_top
